// file: verilog/bwe_host.sv
`timescale 1ns/1ns
`default_nettype none
module bwe_host #(
  parameter int unsigned PWRUP_CYC = bwe_pkg::PWRUP_CYC,
  parameter int unsigned CLR_CYC   = bwe_pkg::CLR_CYC,
  parameter int unsigned WC_CYC    = bwe_pkg::WC_STD_CYC,
  parameter bit          HAS_RDY   = 1'b1
) (
  input  wire logic              i_clk,      // 50 MHz clock
  input  wire logic              i_resetn,   // Async reset, active low
  input  wire logic              i_req,      // Command request, taken when ready
  input  wire bwe_pkg::bwe_cmd_s i_cmd,      // Operation, address, write byte
  output logic                   o_ready,    // Idle, next request accepted
  output logic                   o_done,     // One-cycle completion pulse
  output logic                   o_timeout,  // With done: write never finished
  output logic [7:0]             o_rdata,    // Byte read or polled
  output bwe_pkg::bwe_pins_s     o_pins,     // Memory control, address, data out
  input  wire logic [7:0]        i_data,     // Data lines as seen on the pins
  input  wire logic              i_rdy_busy  // Ready/busy line, low while busy
);
  // Sequencer states, one per phase of a pin-level access
  typedef enum {ST_PWRUP, ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_TDB, ST_WAIT,
                ST_POLL, ST_READ, ST_FINISH} bwe_state_e;

  // Sequencer, interval counter and write watchdog
  bwe_state_e         state;
  bwe_state_e         next_state;
  bwe_pkg::bwe_cnt_t  cnt;
  bwe_pkg::bwe_cnt_t  next_cnt;
  bwe_pkg::bwe_cnt_t  wc;
  bwe_pkg::bwe_cmd_s  cmd;
  bwe_pkg::bwe_cmd_s  cur;

  // Decoded command and one-cycle strobes
  logic               is_clear;
  logic               next_tmo;
  logic               next_cap;

  // Command in force: the request itself on the accepting edge
  assign cur = (state == ST_IDLE) ? i_cmd : cmd;
  assign is_clear = (cur.op == bwe_pkg::OP_CLEAR);

  // Sequencer; one command at a time, so no access overlaps a busy device unless a write timed out
  always_comb begin
    next_state = state;
    next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
    next_tmo = 1'b0;
    next_cap = 1'b0;
    unique case (state)
      // Supply lockout: the part takes no write until this runs out
      ST_PWRUP: begin
        if (cnt == '0) next_state = ST_IDLE;               // [R15]
      end

      // Reads go straight to the access; writes and clears start with setup
      ST_IDLE: begin
        if (i_req && i_cmd.op == bwe_pkg::OP_READ) begin
          next_state = ST_READ;                            // [R13]
          next_cnt = bwe_pkg::bwe_cnt_t'(bwe_pkg::ACC_CYC - 1);
        end else if (i_req && is_clear) begin
          next_state = ST_SETUP;
          next_cnt = bwe_pkg::bwe_cnt_t'(bwe_pkg::CLR_SH_CYC - 1);
        end else if (i_req) begin
          next_state = ST_SETUP;
          next_cnt = bwe_pkg::bwe_cnt_t'(bwe_pkg::AS_CYC - 1);
        end
      end

      // Address settles before the strobe falls; clear waits for the high voltage
      ST_SETUP: begin
        if (cnt == '0 && is_clear) begin
          next_state = ST_PULSE;
          next_cnt = bwe_pkg::bwe_cnt_t'(CLR_CYC - 1);     // [R16]
        end else if (cnt == '0) begin
          next_state = ST_PULSE;
          next_cnt = bwe_pkg::bwe_cnt_t'(bwe_pkg::WP_CYC - 1);
        end
      end

      // Strobe low; a short pulse risks a write the part never saw
      ST_PULSE: begin
        if (cnt == '0 && is_clear) begin
          next_state = ST_HOLD;
          next_cnt = bwe_pkg::bwe_cnt_t'(bwe_pkg::CLR_SH_CYC - 1);
        end else if (cnt == '0) begin
          next_state = ST_HOLD;
          next_cnt = bwe_pkg::bwe_cnt_t'(bwe_pkg::DH_CYC - 1); // [R5]
        end
      end

      // Data still driven past the rising strobe; clear has no busy phase to watch
      ST_HOLD: begin
        if (cnt == '0 && is_clear) begin
          next_state = ST_FINISH;
        end else if (cnt == '0) begin
          next_state = ST_TDB;
          next_cnt = bwe_pkg::bwe_cnt_t'(bwe_pkg::DB_CYC - 1);
        end
      end

      // Busy flag may lag the pulse; do not look before it is valid
      ST_TDB: begin
        if (cnt == '0) begin
          next_state = HAS_RDY ? ST_WAIT : ST_POLL;        // [R10]
          next_cnt = bwe_pkg::bwe_cnt_t'(bwe_pkg::ACC_CYC - 1);
        end
      end

      // Ready line watched every cycle; the watchdog covers a part that never ends
      ST_WAIT: begin
        if (i_rdy_busy) begin
          next_state = ST_FINISH;                          // [R9]
        end else if (wc == '0) begin
          next_state = ST_FINISH;                          // [R8]
          next_tmo = 1'b1;
        end
      end

      // Bit 7 reads inverted until the write is done; resample once per access time
      ST_POLL: begin
        if (cnt == '0 && i_data[7] == cmd.wdata[7]) begin
          next_state = ST_FINISH;                          // [R12]
          next_cap = 1'b1;
        end else if (cnt == '0 && wc == '0) begin
          next_state = ST_FINISH;                          // [R8]
          next_tmo = 1'b1;
        end else if (cnt == '0) begin
          next_cnt = bwe_pkg::bwe_cnt_t'(bwe_pkg::ACC_CYC - 1); // [R11]
        end
      end

      // Access held for the full access time before the byte is taken
      ST_READ: begin
        if (cnt == '0) begin
          next_state = ST_FINISH;
          next_cap = 1'b1;
        end
      end

      // One cycle of done; the pins are already idle
      ST_FINISH: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State and interval counter
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_PWRUP;
      cnt <= bwe_pkg::bwe_cnt_t'(PWRUP_CYC - 1);         // [R15]
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Write cycle watchdog, armed as the pulse ends
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wc <= '0;
    end else if (state == ST_HOLD) begin
      // Reloaded on every write; the count must cover the slowest part option
      wc <= bwe_pkg::bwe_cnt_t'(WC_CYC - 1);               // [R8]
    end else if (wc != '0) begin
      wc <= wc - 1'b1;
    end
  end

  // Command copy, so the user may change inputs once accepted
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd <= '0;
    end else if (state == ST_IDLE && i_req) begin
      cmd <= i_cmd;
    end
  end

  // Pins follow the next state, so each comes from a flip-flop
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pins <= bwe_pkg::PINS_IDLE;                        // [R18]
    end else begin
      o_pins <= bwe_pkg::PINS_IDLE;                        // [R6] [R18]
      if (next_state inside {ST_SETUP, ST_PULSE, ST_HOLD}) begin
        // Write or clear: output enable stays high so the part listens
        o_pins.ce_n <= 1'b0;                               // [R4] [R14]
        o_pins.addr <= cur.addr;                           // [R5]
        o_pins.a9_hv <= cur.id_area;                       // [R17]
        o_pins.oe_hv <= is_clear;                          // [R16]
        o_pins.data_oe <= !is_clear;
        o_pins.data <= cur.wdata;                          // [R5]
        o_pins.we_n <= (next_state != ST_PULSE);           // [R4]
      end else if (next_state inside {ST_READ, ST_POLL}) begin
        // Read or poll: data lines left to the part
        o_pins.ce_n <= 1'b0;                               // [R2]
        o_pins.oe_n <= 1'b0;                               // [R2] [R3]
        o_pins.addr <= cur.addr;
        o_pins.a9_hv <= cur.id_area;                       // [R17]
      end
    end
  end

  // User side status and read data
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ready <= 1'b0;
      o_done <= 1'b0;
      o_timeout <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      o_ready <= (next_state == ST_IDLE);                  // [R13] [R19]
      o_done <= (next_state == ST_FINISH);
      o_timeout <= next_tmo;
      // Timeout leaves the last good byte in place
      if (next_cap) begin
        o_rdata <= i_data;                                 // [R1] [R12]
      end
    end
  end
endmodule : bwe_host
`default_nettype wire

// file: verilog/bwe_pkg.sv
// What this block does
// [R1] 8192 bytes, 13 address, 8 data lines
// [R2] Read: chip enable, output enable low, strobe high
// [R3] Release data lines whenever output enable low
// [R4] Write pulse on strobe, output enable held high
// [R5] Address set before pulse, data held past rise
// [R6] Bus released once write pulse ends
// [R7] Device erases then programs by itself
// [R8] Write cycle ends within 1ms or 200us
// [R9] Ready/busy low while device writes
// [R10] Without ready pin, detect end by polling
// [R11] Bit 7 reads inverted while busy
// [R12] True byte returned once write finished
// [R13] Wait for write end before next access; on a watchdog timeout the host goes idle regardless
// [R14] No write with enable high or output low
// [R15] Wait 5ms after power before writing
// [R16] Chip clear: 12V output enable, 10ms strobe
// [R17] Address bit nine at 12V selects identification bytes
// [R18] Deselect holds device in standby
// [R19] Device ignores write pulses while busy
package bwe_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 50;

  // Times in their own units, counts derived at the clock rate
  localparam int T_AS_NS = 10;
  localparam int T_WP_NS = 100;
  localparam int T_DH_NS = 10;
  localparam int T_DB_NS = 50;
  localparam int T_ACC_NS = 150;
  localparam int T_CLR_SH_US = 1;
  localparam int T_CLR_MS = 10;
  localparam int T_PWRUP_MS = 5;
  localparam int T_WC_STD_US = 1000;
  localparam int T_WC_FAST_US = 200;

  localparam int AS_CYC = (T_AS_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int DH_CYC = (T_DH_NS * CLK_MHZ + 999) / 1000;
  localparam int DB_CYC = (T_DB_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int CLR_SH_CYC = T_CLR_SH_US * CLK_MHZ;
  localparam int CLR_CYC = T_CLR_MS * 1000 * CLK_MHZ;
  localparam int PWRUP_CYC = T_PWRUP_MS * 1000 * CLK_MHZ;
  localparam int WC_STD_CYC = T_WC_STD_US * CLK_MHZ;
  localparam int WC_FAST_CYC = T_WC_FAST_US * CLK_MHZ;

  typedef logic [18:0] bwe_cnt_t;

  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_CLEAR} bwe_op_e;

  typedef struct packed {
    bwe_op_e               op;
    logic                  id_area;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
  } bwe_cmd_s;

  typedef struct packed {
    logic                  ce_n;
    logic                  oe_n;
    logic                  we_n;
    logic                  oe_hv;
    logic                  a9_hv;
    logic                  data_oe;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     data;
  } bwe_pins_s;

  localparam bwe_pins_s PINS_IDLE = '{ce_n: 1'h1, oe_n: 1'h1, we_n: 1'h1, oe_hv: 1'h0,
                                      a9_hv: 1'h0, data_oe: 1'h0, addr: 13'h0000,
                                      data: 8'h00};
endpackage : bwe_pkg

// file: verification/bwe_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module bwe_mem_model #(
  parameter int BUSY_CYC = 60,
  parameter int LOCK_CYC = 20
) (
  input  wire logic              i_clk,    // Bench clock, samples pins
  input  wire bwe_pkg::bwe_pins_s i_pins,  // Host pins
  input  wire logic [7:0]        i_data,   // Resolved data lines
  input  wire logic              i_stuck,  // Hold a started write busy
  output logic [7:0]             o_data,   // Byte driven when selected
  output logic                   o_drive,  // Drives data lines
  output logic                   o_busy    // Pulls ready/busy low
);
  logic [7:0]  mem [0:8223];  // Main bytes, then 32 id bytes
  logic [13:0] lat;
  logic [13:0] idx;
  logic        pwe = 1'h1;
  int          cnt = 0;
  int          lock = LOCK_CYC;  // Supply lockout, counted from time zero
  // Id area sits above the main array, reached only with high voltage on bit nine
  assign idx = i_pins.a9_hv ? 14'h2000 + i_pins.addr[4:0] : {1'h0, i_pins.addr};
  assign o_drive = !i_pins.ce_n && !i_pins.oe_n && i_pins.we_n;
  assign o_busy = (cnt != 0);
  // Low bits during busy change each cycle unless stuck, as the part leaves them undefined
  assign o_data = o_busy ? {~mem[lat][7], cnt[6:0]} : mem[idx];
  // Write pulse decode; a busy part ignores every new pulse
  always @(posedge i_clk) begin
    pwe <= i_pins.we_n;
    if (lock != 0) lock <= lock - 1;
    if (cnt != 0 && !i_stuck) cnt <= cnt - 1;
    if (lock == 0 && !o_busy && !i_pins.ce_n && i_pins.oe_n && !i_pins.we_n && pwe) begin
      lat <= idx;
    end
    if (lock == 0 && !o_busy && !i_pins.ce_n && i_pins.we_n && !pwe) begin
      if (i_pins.oe_hv) begin
        for (int i = 0; i < 8192; i++) mem[i] <= 8'hFF;
      end else begin
        mem[lat] <= i_data;
        cnt <= BUSY_CYC;
      end
    end
  end
endmodule : bwe_mem_model
`default_nettype wire

// file: verification/bwe_host_checker.sv
`timescale 1ns/1ns
`default_nettype none
module bwe_host_checker (
  input wire logic               i_clk,       // Clock
  input wire logic               i_resetn,    // Reset, active low
  input wire logic               i_req,       // Request
  input wire bwe_pkg::bwe_cmd_s  i_cmd,       // Command
  input wire logic               o_ready,     // Idle
  input wire logic               o_done,      // Completion
  input wire logic               o_timeout,   // Write never ended
  input wire bwe_pkg::bwe_pins_s o_pins,      // Pins
  input wire logic               i_rdy_busy   // Ready/busy wire
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic take;
  assign take = i_req && o_ready;
  property p_rd; take && i_cmd.op == bwe_pkg::OP_READ |-> ##9 o_done; endproperty
  a_rd: assert property (p_rd) else $error("read latency wrong");
  property p_wr;
    take && i_cmd.op == bwe_pkg::OP_WRITE |=> !o_pins.ce_n && o_pins.data_oe && o_pins.we_n
      ##1 !o_pins.we_n [*5] ##1 o_pins.we_n && o_pins.data_oe;
  endproperty
  a_wr: assert property (p_wr) else $error("write pulse shape wrong");
  property p_oe; !o_pins.we_n |-> o_pins.oe_n && !o_pins.ce_n; endproperty
  a_oe: assert property (p_oe) else $error("strobe low without write mode");
  property p_cont; o_pins.data_oe |-> o_pins.oe_n; endproperty
  a_cont: assert property (p_cont) else $error("bus contention");
  property p_clr; take && i_cmd.op == bwe_pkg::OP_CLEAR |=> o_pins.oe_hv && !o_pins.ce_n; endproperty
  a_clr: assert property (p_clr) else $error("clear setup wrong");
  property p_id; take && i_cmd.id_area |=> o_pins.a9_hv; endproperty
  a_id: assert property (p_id) else $error("id area not selected");
  property p_busy; $fell(o_pins.we_n) |-> $past(i_rdy_busy); endproperty
  a_busy: assert property (p_busy) else $error("write started while busy");
  property p_to; o_timeout |-> o_done ##1 o_ready; endproperty
  a_to: assert property (p_to) else $error("timeout not with done");
endmodule : bwe_host_checker
`default_nettype wire

// file: verification/bwe_host_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bwe_host_tb;
  logic clk, rst_n, req, o_ready, o_done, o_to, stuck, m_drive, m_busy;
  logic o_ready2, o_done2, o_to2, m_drive2, poll_to;
  logic [7:0] o_rdata, m_data, din, pat;
  logic [7:0] o_rdata2, m_data2, din2, poll_rd;
  bwe_pkg::bwe_cmd_s cmd;
  bwe_pkg::bwe_pins_s pins, pins2;
  int err_total = 0;
  int cmp_count = 0;
  bwe_host #(.PWRUP_CYC(10), .CLR_CYC(20), .WC_CYC(200), .HAS_RDY(1'b1)) i_dut (
    .i_clk(clk), .i_resetn(rst_n), .i_req(req), .i_cmd(cmd), .o_ready(o_ready),
    .o_done(o_done), .o_timeout(o_to), .o_rdata(o_rdata), .o_pins(pins),
    .i_data(din), .i_rdy_busy(~m_busy));
  bwe_mem_model i_mem (.i_clk(clk), .i_pins(pins), .i_data(din), .i_stuck(stuck),
    .o_data(m_data), .o_drive(m_drive), .o_busy(m_busy));
  // Second host without the ready line, its pin left open on a pull-up
  bwe_host #(.PWRUP_CYC(10), .CLR_CYC(20), .WC_CYC(200), .HAS_RDY(1'b0)) i_dut_poll (
    .i_clk(clk), .i_resetn(rst_n), .i_req(req), .i_cmd(cmd), .o_ready(o_ready2),
    .o_done(o_done2), .o_timeout(o_to2), .o_rdata(o_rdata2), .o_pins(pins2),
    .i_data(din2), .i_rdy_busy(1'b1));
  bwe_mem_model i_mem_poll (.i_clk(clk), .i_pins(pins2), .i_data(din2), .i_stuck(stuck),
    .o_data(m_data2), .o_drive(m_drive2), .o_busy());
  // Undriven lines show a changing pattern, never the last value
  assign din = pins.data_oe ? pins.data : (m_drive ? m_data : pat);
  assign din2 = pins2.data_oe ? pins2.data : (m_drive2 ? m_data2 : pat);
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) pat <= pat + 8'h01;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic do_cmd(input bwe_pkg::bwe_op_e op, input logic id, input logic [12:0] a,
                        input logic [7:0] d, output logic [7:0] rd, output logic to);
    int n;
    logic seen1;
    logic seen2;
    n = 0;
    seen1 = 1'b0;
    seen2 = 1'b0;
    rd = 8'h00;
    to = 1'b0;
    // Both hosts take the same request on the same edge
    while (o_ready !== 1'b1 || o_ready2 !== 1'b1) @(posedge clk);
    req <= 1'h1;
    cmd <= '{op: op, id_area: id, addr: a, wdata: d};
    @(posedge clk);
    req <= 1'h0;
    // Each done stands one cycle; results are taken while it stands
    do begin
      @(posedge clk);
      #1;
      n++;
      if (o_done === 1'b1) begin
        seen1 = 1'b1;
        rd = o_rdata;
        to = o_to;
      end
      if (o_done2 === 1'b1) begin
        seen2 = 1'b1;
        poll_rd = o_rdata2;
        poll_to = o_to2;
      end
    end while (!(seen1 && seen2) && n < 2000);
    chk({6'h00, seen1, seen2}, 8'h03);
    @(posedge clk);
  endtask : do_cmd
  task automatic t_wr_rd;
    logic [7:0] r;
    logic t;
    do_cmd(bwe_pkg::OP_WRITE, 1'h0, 13'h0123, 8'hA5, r, t);
    chk({6'h00, t, poll_to}, 8'h00);
    chk(poll_rd, 8'hA5);
    do_cmd(bwe_pkg::OP_WRITE, 1'h0, 13'h1FE0, 8'h3C, r, t);
    chk(poll_rd, 8'h3C);
    do_cmd(bwe_pkg::OP_READ, 1'h0, 13'h0123, 8'h00, r, t);
    chk(r, 8'hA5);
    chk(poll_rd, 8'hA5);
    do_cmd(bwe_pkg::OP_WRITE, 1'h1, 13'h1FE0, 8'h81, r, t);
    chk(poll_rd, 8'h81);
    do_cmd(bwe_pkg::OP_READ, 1'h0, 13'h1FE0, 8'h00, r, t);
    chk(r, 8'h3C);
    do_cmd(bwe_pkg::OP_READ, 1'h1, 13'h1FE0, 8'h00, r, t);
    chk(r, 8'h81);
  endtask : t_wr_rd
  task automatic t_clr_to;
    logic [7:0] r;
    logic t;
    do_cmd(bwe_pkg::OP_CLEAR, 1'h0, 13'h0000, 8'h00, r, t);
    do_cmd(bwe_pkg::OP_READ, 1'h0, 13'h0123, 8'h00, r, t);
    chk(r, 8'hFF);
    chk(poll_rd, 8'hFF);
    stuck <= 1'h1;
    do_cmd(bwe_pkg::OP_WRITE, 1'h0, 13'h0007, 8'h12, r, t);
    chk({6'h00, t, poll_to}, 8'h03);
    stuck <= 1'h0;
  endtask : t_clr_to
  task automatic wrap_up;
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    rst_n = 0;
    req = 0;
    cmd = '0;
    stuck = 0;
    pat = 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    t_wr_rd();
    t_clr_to();
    wrap_up();
  end
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
endmodule : bwe_host_tb
bind bwe_host bwe_host_checker i_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(i_req),
  .i_cmd(i_cmd), .o_ready(o_ready), .o_done(o_done), .o_timeout(o_timeout),
  .o_pins(o_pins), .i_rdy_busy(i_rdy_busy));
`default_nettype wire
